// >>> core/atc_pkg.sv
// Shared constants for the acquisition trigger control block.
package atc_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] ATC_OFF_CMD       = 8'h00;
  localparam logic [7:0] ATC_OFF_MODE      = 8'h04;
  localparam logic [7:0] ATC_OFF_FCOUNT    = 8'h08;
  localparam logic [7:0] ATC_OFF_PERIOD    = 8'h0C;
  localparam logic [7:0] ATC_OFF_MINPERIOD = 8'h10;
  localparam logic [7:0] ATC_OFF_EXPOSURE  = 8'h14;
  localparam logic [7:0] ATC_OFF_READOUT   = 8'h18;
  localparam logic [7:0] ATC_OFF_DEBOUNCE  = 8'h1C;
  localparam logic [7:0] ATC_OFF_STATUS    = 8'h20;
  localparam logic [7:0] ATC_OFF_DONE      = 8'h24;

  // Command register bits, write-one pulses.
  localparam int ATC_CMD_START = 0;
  localparam int ATC_CMD_STOP  = 1;
  localparam int ATC_CMD_SWTRG = 2;

  // Mode register fields.
  localparam int ATC_MODE_ACQ_LSB  = 0;
  localparam int ATC_MODE_TRG_ON   = 2;
  localparam int ATC_MODE_FALLING  = 3;
  localparam int ATC_MODE_SRC_LSB  = 4;

  // Acquisition mode encodings.
  localparam logic [1:0] ATC_ACQ_CONTINUOUS = 2'h0;
  localparam logic [1:0] ATC_ACQ_ONE_SHOT   = 2'h1;
  localparam logic [1:0] ATC_ACQ_COUNTED    = 2'h2;

  // Trigger source encodings when triggering is on.
  localparam logic [1:0] ATC_SRC_LINE     = 2'h0;
  localparam logic [1:0] ATC_SRC_SOFTWARE = 2'h1;

  // Reset values.
  localparam logic [31:0] ATC_RST_MODE      = 32'h0000_0000;
  localparam logic [31:0] ATC_RST_FCOUNT    = 32'h0000_0001;
  localparam logic [31:0] ATC_RST_PERIOD    = 32'h0001_0000;
  localparam logic [31:0] ATC_RST_MINPERIOD = 32'h0000_1000;
  localparam logic [31:0] ATC_RST_EXPOSURE  = 32'h0000_0400;
  localparam logic [31:0] ATC_RST_READOUT   = 32'h0000_0800;
  localparam logic [31:0] ATC_RST_DEBOUNCE  = 32'h0000_0010;

  // Sequencer states.
  typedef enum logic [3:0] {
    ATC_ST_IDLE   = 4'b0001,
    ATC_ST_WAIT   = 4'b0010,
    ATC_ST_EXPOSE = 4'b0100,
    ATC_ST_READ   = 4'b1000
  } atc_state_t;

endpackage : atc_pkg

// >>> core/atc_debounce.sv
// Synchroniser and width qualifier for the hardware trigger input.
`timescale 1ns/1ns
`default_nettype none
module atc_debounce #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Pin and settings
  input  wire logic         pin_in,
  input  wire logic [W-1:0] width,
  // Qualified level
  output logic              level_out
);
  logic         sync1_reg;
  logic         sync2_reg;
  logic [W-1:0] cnt_reg;
  wire          differs = sync2_reg != level_out;
  wire          long_enough = cnt_reg + 1'b1 >= width;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // A new level is accepted only after it has held for the programmed width.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg   <= '0;
      level_out <= 1'b0;
    end else if (!differs) begin
      cnt_reg <= '0;
    end else if (long_enough) begin
      level_out <= sync2_reg;
      cnt_reg   <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : atc_debounce
`default_nettype wire

// >>> core/atc_rategen.sv
// Free-run exposure start generator with a floor on the period.
`timescale 1ns/1ns
`default_nettype none
module atc_rategen #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Control
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] min_period,
  // Tick
  output logic              tick
);
  logic [W-1:0] cnt_reg;
  // A requested rate above the maximum falls back to the shortest allowed period.
  wire  [W-1:0] eff_period = (period < min_period) ? min_period : period;
  wire          wrap = cnt_reg + 1'b1 >= eff_period;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= wrap;
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
    end
  end
endmodule : atc_rategen
`default_nettype wire

// >>> core/atc_top.sv
// Acquisition sequencer with AHB-Lite registers, trigger qualification and strobe.
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - No frame is acquired before a start command runs.
// - A stop command removes the ability to acquire more frames.
// - Continuous mode acquires frames from start until stop.
// - One-shot mode acquires one frame then stops by itself.
// - Counted mode acquires the programmed number of frames then stops.
// - A stop during a frame lets that frame finish first.
// - After a stop, nothing is acquired until a new start.
// - A trigger while waiting starts exposure followed by readout.
// - The sequencer returns to waiting as soon as it can accept triggers.
// - With triggering off, triggers come from an internal rate generator.
// - With triggering on, each external trigger starts one exposure.
// - Triggers arriving outside the waiting state are discarded.
// - The hardware trigger must hold for the debounce width to count.
// - The strobe output is high for the exposure of each frame.
// - A setting selects rising or falling edge as the trigger.
// - Free-run rate is clamped to the maximum allowed rate.
module atc_top
  import atc_pkg::*;
#(
  parameter int CW = 32
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Camera pins and status
  input  wire logic        trigger_pin,
  input  wire logic        link_trigger,
  output logic             strobe_out,
  output logic             acquiring,
  output logic             frame_start
);
  // Register state.
  logic [31:0] mode_reg;
  logic [31:0] frame_count_target;
  logic [31:0] period_reg;
  logic [31:0] minperiod_reg;
  logic [31:0] exposure_reg;
  logic [31:0] readout_reg;
  logic [31:0] debounce_reg;
  logic [31:0] done_reg;
  logic [CW-1:0] timer_reg;
  logic        armed_reg;
  logic        stop_pend_reg;
  logic        swtrg_reg;
  logic        link_s1_reg;
  logic        link_s2_reg;
  logic        trig_prev_reg;
  atc_state_t  state_reg;
  atc_state_t  state_next;

  // Address phase capture.
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;

  wire         bus_go = hsel && hready && htrans[1];
  wire         wr_hit = wr_pend_reg;
  wire         do_start = wr_hit && addr_reg == ATC_OFF_CMD && hwdata[ATC_CMD_START];
  wire         do_stop = wr_hit && addr_reg == ATC_OFF_CMD && hwdata[ATC_CMD_STOP];
  wire         do_swtrg = wr_hit && addr_reg == ATC_OFF_CMD && hwdata[ATC_CMD_SWTRG];

  // Mode fields.
  wire [1:0]   acq_mode = mode_reg[ATC_MODE_ACQ_LSB +: 2];
  wire         trg_on = mode_reg[ATC_MODE_TRG_ON];
  wire         falling = mode_reg[ATC_MODE_FALLING];
  wire [1:0]   src = mode_reg[ATC_MODE_SRC_LSB +: 2];

  // Trigger qualification.
  logic        line_level;
  logic        free_tick;

  atc_debounce #(.W(32)) u_debounce (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    (trigger_pin),
    .width     (debounce_reg),
    .level_out (line_level)
  );

  wire         waiting = state_reg == ATC_ST_WAIT;

  // The generator runs for the whole acquisition, so the frame period is the programmed
  // period and not that period plus the frame time; ticks outside the wait state fall away.
  atc_rategen #(.W(32)) u_rategen (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .run        (armed_reg && !trg_on),
    .period     (period_reg),
    .min_period (minperiod_reg),
    .tick       (free_tick)
  );

  wire         ext_level = (src == ATC_SRC_LINE) ? line_level : link_s2_reg;
  wire         rise = ext_level && !trig_prev_reg;
  wire         fall = !ext_level && trig_prev_reg;
  wire         edge_hit = falling ? fall : rise;
  wire         ext_trig = (src == ATC_SRC_SOFTWARE) ? swtrg_reg : edge_hit;
  wire         trig = trg_on ? ext_trig : free_tick;
  // Triggers are only looked at in the waiting state; elsewhere they fall away.
  wire         accept = waiting && armed_reg && !stop_pend_reg && trig;
  wire         timer_done = timer_reg == '0;
  wire [31:0]  done_inc = done_reg + 32'h0000_0001;
  wire         last_frame = (acq_mode == ATC_ACQ_ONE_SHOT) ||
                            (acq_mode == ATC_ACQ_COUNTED && done_inc >= frame_count_target);
  wire         frame_end = state_reg == ATC_ST_READ && timer_done;

  // Sequencer.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ATC_ST_IDLE: begin
        if (armed_reg) begin
          state_next = ATC_ST_WAIT;
        end
      end
      ATC_ST_WAIT: begin
        if (!armed_reg || stop_pend_reg) begin
          state_next = ATC_ST_IDLE;
        end else if (accept) begin
          state_next = ATC_ST_EXPOSE;
        end
      end
      ATC_ST_EXPOSE: begin
        if (timer_done) begin
          state_next = ATC_ST_READ;
        end
      end
      ATC_ST_READ: begin
        if (timer_done) begin
          // A pending stop takes effect only once the frame has been read out.
          state_next = (stop_pend_reg || last_frame || do_stop) ? ATC_ST_IDLE : ATC_ST_WAIT;
        end
      end
      default: state_next = ATC_ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ATC_ST_IDLE;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        timer_reg <= exposure_reg[CW-1:0];
      end else if (state_reg == ATC_ST_EXPOSE && timer_done) begin
        timer_reg <= readout_reg[CW-1:0];
      end else if (!timer_done) begin
        timer_reg <= timer_reg - 1'b1;
      end
    end
  end

  // Arm, stop and frame counting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_reg     <= 1'b0;
      stop_pend_reg <= 1'b0;
      done_reg      <= '0;
    end else begin
      if (do_start && !armed_reg) begin
        armed_reg     <= 1'b1;
        stop_pend_reg <= 1'b0;
        done_reg      <= '0;
      end else if (frame_end) begin
        done_reg <= done_inc;
        // A stop that lands on the last readout cycle still ends the acquisition.
        if (stop_pend_reg || last_frame || do_stop) begin
          armed_reg     <= 1'b0;
          stop_pend_reg <= 1'b0;
        end
      end else if (do_stop) begin
        // A stop that meets an accepted trigger lets that frame run to its end.
        if (accept || state_reg == ATC_ST_EXPOSE || state_reg == ATC_ST_READ) begin
          stop_pend_reg <= 1'b1;
        end else begin
          armed_reg <= 1'b0;
        end
      end
      // Continuous mode keeps armed_reg set until a stop arrives.
      if (acq_mode == ATC_ACQ_CONTINUOUS && frame_end && !stop_pend_reg && !do_stop) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // Trigger edge history and link trigger synchroniser.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_s1_reg   <= 1'b0;
      link_s2_reg   <= 1'b0;
      trig_prev_reg <= 1'b0;
      swtrg_reg     <= 1'b0;
    end else begin
      link_s1_reg   <= link_trigger;
      link_s2_reg   <= link_s1_reg;
      trig_prev_reg <= ext_level;
      swtrg_reg     <= do_swtrg;
    end
  end

  // Pin and status outputs, all registered.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_out  <= 1'b0;
      acquiring   <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      strobe_out  <= state_next == ATC_ST_EXPOSE;
      acquiring   <= armed_reg;
      frame_start <= accept;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= bus_go && hwrite;
      rd_pend_reg <= bus_go && !hwrite;
      if (bus_go) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg           <= ATC_RST_MODE;
      frame_count_target <= ATC_RST_FCOUNT;
      period_reg         <= ATC_RST_PERIOD;
      minperiod_reg      <= ATC_RST_MINPERIOD;
      exposure_reg       <= ATC_RST_EXPOSURE;
      readout_reg        <= ATC_RST_READOUT;
      debounce_reg       <= ATC_RST_DEBOUNCE;
    end else if (wr_hit) begin
      case (addr_reg)
        ATC_OFF_MODE:      mode_reg <= hwdata;
        ATC_OFF_FCOUNT:    frame_count_target <= hwdata;
        ATC_OFF_PERIOD:    period_reg <= hwdata;
        ATC_OFF_MINPERIOD: minperiod_reg <= hwdata;
        ATC_OFF_EXPOSURE:  exposure_reg <= hwdata;
        ATC_OFF_READOUT:   readout_reg <= hwdata;
        ATC_OFF_DEBOUNCE:  debounce_reg <= hwdata;
        default: ;
      endcase
    end
  end

  // Read data is presented in the data phase; unmapped offsets read zero.
  wire [31:0] status_word = {26'h0, stop_pend_reg, armed_reg, state_reg};
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      ATC_OFF_MODE:      rd_mux = mode_reg;
      ATC_OFF_FCOUNT:    rd_mux = frame_count_target;
      ATC_OFF_PERIOD:    rd_mux = period_reg;
      ATC_OFF_MINPERIOD: rd_mux = minperiod_reg;
      ATC_OFF_EXPOSURE:  rd_mux = exposure_reg;
      ATC_OFF_READOUT:   rd_mux = readout_reg;
      ATC_OFF_DEBOUNCE:  rd_mux = debounce_reg;
      ATC_OFF_STATUS:    rd_mux = status_word;
      ATC_OFF_DONE:      rd_mux = done_reg;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data comes straight from a flop, captured from the address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_go && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

endmodule : atc_top
`default_nettype wire

// >>> dv/atc_monitor.sv
// Port-level checker for the acquisition trigger control block.
`timescale 1ns/1ns
`default_nettype none
module atc_monitor
  import atc_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Camera side
  input wire logic        strobe_out,
  input wire logic        acquiring,
  input wire logic        frame_start
);
  logic cmd_ap_reg;
  // A start is only visible in the data phase, so the address phase is remembered here.
  wire  start_dp = cmd_ap_reg && hwdata[ATC_CMD_START];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_ap_reg <= 1'b0;
    end else if (hready) begin
      cmd_ap_reg <= hsel && htrans[1] && hwrite && haddr[7:0] == ATC_OFF_CMD;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_rose_strobe: assert property ($rose(strobe_out) |-> frame_start)
    else $error("strobe rose without a frame start");
  a_start_strobe: assert property (frame_start |-> strobe_out)
    else $error("frame start without strobe");
  a_frame_armed: assert property (frame_start |-> $past(acquiring))
    else $error("frame started while not armed");
  a_armed_cause: assert property ($rose(acquiring) |-> $past(start_dp) || $past(start_dp, 2))
    else $error("armed without a start command");
  a_pulse_one: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  a_no_retrig: assert property (strobe_out && $past(strobe_out) |-> !frame_start)
    else $error("trigger accepted during exposure");
  a_fall_idle: assert property ($fell(acquiring) |-> !strobe_out && !$past(strobe_out))
    else $error("acquisition ended inside an exposure");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answered with wait or error");
  c_frame: cover property (frame_start);
  c_stop: cover property ($fell(acquiring));
  c_start: cover property (start_dp);
endmodule : atc_monitor
bind atc_top atc_monitor i_atc_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .strobe_out, .acquiring, .frame_start);
`default_nettype wire

// >>> dv/atc_trig_src.sv
// Trigger source model driving the hardware and link trigger lines.
`timescale 1ns/1ns
`default_nettype none
module atc_trig_src (
  // Clock
  input  wire logic       hclk,
  // Requests
  input  wire logic       fire_pin,
  input  wire logic       fire_link,
  input  wire logic [7:0] width,
  input  wire logic       falling,
  // Trigger lines
  output logic            trigger_pin,
  output logic            link_trigger
);
  logic [7:0] pin_cnt  = 8'h00;
  logic [7:0] link_cnt = 8'h00;
  always @(posedge hclk) begin
    pin_cnt  <= fire_pin ? width : (pin_cnt != 8'h00 ? pin_cnt - 8'h01 : 8'h00);
    link_cnt <= fire_link ? 8'h04 : (link_cnt != 8'h00 ? link_cnt - 8'h01 : 8'h00);
  end
  // The idle level flips with polarity, so a pulse always starts with the watched edge.
  assign trigger_pin  = (pin_cnt != 8'h00) ^ falling;
  assign link_trigger = (link_cnt != 8'h00) ^ falling;
endmodule : atc_trig_src
`default_nettype wire

// >>> dv/test_acquisition_trigger_control.sv
// Self-checking bench for the acquisition trigger control block.
`timescale 1ns/1ns
`default_nettype none
module test_acquisition_trigger_control;
  import atc_pkg::*;
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        fire_pin  = 1'b0;
  logic        fire_link = 1'b0;
  logic        falling   = 1'b0;
  logic [7:0]  width     = 8'h00;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, strobe_out, acquiring, frame_start, trigger_pin, link_trigger;
  int          n_fail = 0, n_checks = 0, frames = 0, sw = 0, last_sw = 0;
  atc_top i_atc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .trigger_pin, .link_trigger, .strobe_out,
    .acquiring, .frame_start);
  atc_trig_src i_atc_trig_src (.hclk, .fire_pin, .fire_link, .width, .falling, .trigger_pin,
    .link_trigger);
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (frame_start === 1'b1) frames <= frames + 1;
    if (strobe_out === 1'b1) sw <= sw + 1;
    else if (sw != 0) begin
      last_sw <= sw;
      sw <= 0;
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdc
  task automatic cmd(input int b);
    bus(1'b1, ATC_OFF_CMD, 32'h1 << b);
  endtask : cmd
  // Triggers are spaced by the given gap; a gap of 0 lets the next trigger land inside the running frame.
  task automatic swt(input int gap);
    cmd(ATC_CMD_SWTRG);
    repeat (gap) @(posedge hclk);
  endtask : swt
  task automatic trg(input logic lk, input logic [7:0] w);
    @(posedge hclk);
    width <= w;
    fire_pin <= !lk;
    fire_link <= lk;
    @(posedge hclk);
    fire_pin <= 1'b0;
    fire_link <= 1'b0;
    repeat (40) @(posedge hclk);
  endtask : trg
  function automatic logic [31:0] mw(input logic [1:0] acq, input logic on, input logic fe, input logic [1:0] src);
    mw = 32'h0;
    mw[ATC_MODE_ACQ_LSB+:2] = acq;
    mw[ATC_MODE_TRG_ON] = on;
    mw[ATC_MODE_FALLING] = fe;
    mw[ATC_MODE_SRC_LSB+:2] = src;
  endfunction : mw
  task automatic run_free(input logic [31:0] p, input int lo, input int hi, input string nm);
    int f0;
    bus(1'b1, ATC_OFF_PERIOD, p);
    f0 = frames;
    cmd(ATC_CMD_START);
    repeat (400) @(posedge hclk);
    cmd(ATC_CMD_STOP);
    repeat (20) @(posedge hclk);
    chk(nm, 32'h1, (frames - f0) inside {[lo:hi]});
  endtask : run_free
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    final_report();
  end
  initial begin
    int f0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(ATC_OFF_MODE, '1, ATC_RST_MODE, "mode reset");
    rdc(ATC_OFF_FCOUNT, '1, ATC_RST_FCOUNT, "count reset");
    rdc(8'h30, '1, 32'h0, "unmapped read");
    rdc(ATC_OFF_STATUS, 32'h3F, {28'h0, ATC_ST_IDLE}, "status reset");
    bus(1'b1, ATC_OFF_EXPOSURE, 32'h4);
    bus(1'b1, ATC_OFF_READOUT, 32'h4);
    bus(1'b1, ATC_OFF_DEBOUNCE, 32'h8);
    bus(1'b1, ATC_OFF_MINPERIOD, 32'h14);
    rdc(ATC_OFF_EXPOSURE, '1, 32'h4, "exposure");
    $display("test registers done");
    bus(1'b1, ATC_OFF_MODE, mw(ATC_ACQ_CONTINUOUS, 1'b1, 1'b0, ATC_SRC_SOFTWARE));
    f0 = frames;
    swt(20);
    chk("frames before start", f0, frames);
    cmd(ATC_CMD_START);
    repeat (3) @(posedge hclk);
    chk("armed", 32'h1, acquiring);
    rdc(ATC_OFF_STATUS, 32'h30, 32'h10, "status armed");
    repeat (3) swt(20);
    chk("continuous frames", f0 + 3, frames);
    chk("strobe width", 32'h1, last_sw inside {[4:5]});
    swt(0);
    swt(20);
    chk("retrigger dropped", f0 + 4, frames);
    swt(0);
    cmd(ATC_CMD_STOP);
    @(posedge hclk);
    chk("armed during frame", 32'h1, acquiring);
    repeat (20) @(posedge hclk);
    chk("frame finished", f0 + 5, frames);
    chk("stopped", 32'h0, acquiring);
    swt(20);
    chk("no frame after stop", f0 + 5, frames);
    $display("test continuous done");
    bus(1'b1, ATC_OFF_MODE, mw(ATC_ACQ_ONE_SHOT, 1'b1, 1'b0, ATC_SRC_SOFTWARE));
    f0 = frames;
    cmd(ATC_CMD_START);
    swt(20);
    swt(20);
    chk("one shot frames", f0 + 1, frames);
    chk("one shot stopped", 32'h0, acquiring);
    bus(1'b1, ATC_OFF_FCOUNT, 32'h3);
    bus(1'b1, ATC_OFF_MODE, mw(ATC_ACQ_COUNTED, 1'b1, 1'b0, ATC_SRC_SOFTWARE));
    repeat (2) begin
      f0 = frames;
      cmd(ATC_CMD_START);
      repeat (4) swt(20);
      chk("counted frames", f0 + 3, frames);
      chk("counted stopped", 32'h0, acquiring);
      rdc(ATC_OFF_DONE, '1, 32'h3, "frames done");
    end
    $display("test one shot and counted done");
    bus(1'b1, ATC_OFF_MODE, mw(ATC_ACQ_CONTINUOUS, 1'b1, 1'b0, ATC_SRC_LINE));
    f0 = frames;
    cmd(ATC_CMD_START);
    trg(1'b0, 8'h04);
    trg(1'b0, 8'h0C);
    chk("line rising", f0 + 1, frames);
    cmd(ATC_CMD_STOP);
    falling <= 1'b1;
    bus(1'b1, ATC_OFF_MODE, mw(ATC_ACQ_CONTINUOUS, 1'b1, 1'b1, ATC_SRC_LINE));
    cmd(ATC_CMD_START);
    trg(1'b0, 8'h0C);
    chk("line falling", f0 + 2, frames);
    cmd(ATC_CMD_STOP);
    falling <= 1'b0;
    bus(1'b1, ATC_OFF_MODE, mw(ATC_ACQ_CONTINUOUS, 1'b1, 1'b0, 2'h2));
    cmd(ATC_CMD_START);
    trg(1'b1, 8'h04);
    chk("link trigger", f0 + 3, frames);
    cmd(ATC_CMD_STOP);
    $display("test external triggers done");
    bus(1'b1, ATC_OFF_MODE, mw(ATC_ACQ_CONTINUOUS, 1'b0, 1'b0, ATC_SRC_LINE));
    run_free(32'h28, 9, 11, "free run rate");
    run_free(32'h5, 18, 21, "clamped rate");
    $display("test free run done");
    final_report();
  end
endmodule : test_acquisition_trigger_control
`default_nettype wire
